// File: supply_supervisor_pkg.sv
package supply_supervisor_pkg;

   // register offsets (byte addresses on the register port)
   localparam logic [7:0] BROWNOUT_CONTROL_OFS = 8'h18;
   localparam logic [7:0] POWERON_RESET_MASK_OFS = 8'h24;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h60;
   localparam logic [7:0] IRQ_ENABLE_OFS = 8'h64;
   localparam logic [7:0] IRQ_CLEAR_OFS = 8'h68;

   // brownout_control field positions
   localparam int THR_LO = 16;
   localparam int LVR_DG_LO = 12;
   localparam int BOD_DG_LO = 8;
   localparam int LVR_EN_BIT = 7;
   localparam int LEVEL_STATUS_BIT = 6;
   localparam int LOW_POWER_BIT = 5;
   localparam int FLAG_BIT = 4;
   localparam int RESET_MODE_BIT = 3;
   localparam int ENABLE_BIT = 0;

   // interrupt status / enable / clear layout
   localparam int IRQ_BOD_BIT = 0;
   localparam int IRQ_LVR_ARMED_BIT = 1;
   localparam int IRQ_POR_CANCEL_BIT = 2;
   localparam int IRQ_W = 3;

   // user configuration word positions
   localparam int CFG_THR_LO = 21;
   localparam int CFG_ENABLE_BIT = 23;
   localparam int CFG_RESET_MODE_BIT = 20;

   // values after reset of the fields not loaded from flash
   localparam logic [2:0] LVR_DG_RST = 3'h0;
   localparam logic [2:0] BOD_DG_RST = 3'h3;
   localparam logic LVR_EN_RST = 1'b1;
   localparam logic LOW_POWER_RST = 1'b0;
   localparam logic [15:0] POR_KEY_RST = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 3'h1;

   localparam logic [15:0] POR_MASK_KEY = 16'h5aa5;

   // de-glitch: code 1 selects 4 cycles, each further code doubles
   localparam int DG_BASE_CYCLES = 4;
   localparam int DG_CNT_W = 9;

   // low-voltage reset settling delay
   localparam int CLK_PERIOD_NS = 10;
   localparam int LVR_SETTLE_NS = 200_000;
   localparam int LVR_SETTLE_CYC = (LVR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int RESET_SRC_W = 4;

endpackage

// File: supply_supervisor_control.sv
// Functional notes
// - 3-bit threshold select in bits 18:16, driven to the analog detector.
// - threshold, enable and reset-mode load from the flash configuration word at reset.
// - low-voltage de-glitch: 0 bypasses, 1..7 need 4..256 clock cycles.
// - brown-out de-glitch: 0 samples on slow RC clock, 1..7 filter 4..256 cycles.
// - low-voltage reset enable at bit 7, on by default, resets chip below level.
// - low-voltage output ignored for 200 us after the enable is set.
// - bit 6 reads filtered below-threshold level, always 0 while detector disabled.
// - bit 5 selects detector low-power mode, 0 after reset.
// - flag at bit 4 sets on every crossing while enabled; interrupt requested in interrupt mode.
// - writing 1 to the flag clears it, writing 0 leaves it.
// - enabled and reset mode: chip reset requested while filtered level is below.
// - enabled and interrupt mode: interrupt held until flag cleared; disable blocks it.
// - enable bit 0 gates detector; off means no brown-out reset or interrupt.
// - configuration fields and power-on mask ignore writes unless unlocked.
// - power-on reset masked only while mask field holds 0x5AA5.
// - any other reset source cancels the power-on reset mask.
//
// The plain strobed port was left to the implementer.
module supply_supervisor_control
   import supply_supervisor_pkg::*;
#(
   parameter int LVR_SETTLE_CYCLES = LVR_SETTLE_CYC,
   parameter int SETTLE_CNT_W = 16
) (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [31:0] RDATA_OUT,
   input wire logic PROTECT_UNLOCK_IN,
   input wire logic [31:0] USER_CONFIG_WORD_IN,
   input wire logic BOD_RAW_IN,
   input wire logic LVR_RAW_IN,
   input wire logic SLOW_RC_CLOCK_IN,
   input wire logic [RESET_SRC_W-1:0] RESET_SOURCES_IN,
   output logic [2:0] BOD_THRESHOLD_SEL_OUT,
   output logic BOD_ENABLE_OUT,
   output logic BOD_LOW_POWER_OUT,
   output logic LVR_ENABLE_OUT,
   output logic BOD_RESET_REQ_OUT,
   output logic LVR_RESET_REQ_OUT,
   output logic POR_MASK_OUT,
   output logic IRQ_OUT
);

   typedef struct packed {
      logic bod_s1;
      logic bod_s2;
      logic lvr_s1;
      logic lvr_s2;
      logic rc_s1;
      logic rc_s2;
      logic rc_s3;
      logic [RESET_SRC_W-1:0] src_s1;
      logic [RESET_SRC_W-1:0] src_s2;
      logic [2:0] thr;
      logic [2:0] lvr_dg;
      logic [2:0] bod_dg;
      logic lvr_en;
      logic low_power;
      logic flag;
      logic reset_mode;
      logic bod_en;
      logic [15:0] por_key;
      logic bod_filt;
      logic [DG_CNT_W-1:0] bod_cnt;
      logic lvr_filt;
      logic [DG_CNT_W-1:0] lvr_cnt;
      logic [SETTLE_CNT_W-1:0] settle_cnt;
      logic lvr_armed;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_en;
      logic bod_rst;
      logic lvr_rst;
      logic por_mask;
      logic irq;
      logic [31:0] rdata;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // one filter step: returns {filtered level, counter}
   function automatic logic [DG_CNT_W:0] dg_step(input logic raw, input logic filt,
                                                 input logic [DG_CNT_W-1:0] cnt,
                                                 input logic [2:0] sel, input logic sample,
                                                 input logic bypass);
      logic [DG_CNT_W-1:0] last;
      last = DG_CNT_W'((DG_BASE_CYCLES << (sel - 3'h1)) - 1);
      if (sel == 3'h0) begin
         if (bypass) begin
            dg_step = {raw, {DG_CNT_W{1'b0}}};
         end else begin
            dg_step = {(sample ? raw : filt), {DG_CNT_W{1'b0}}};
         end
      end else if (raw == filt) begin
         // a return to the old level restarts the count
         dg_step = {filt, {DG_CNT_W{1'b0}}};
      end else if (cnt == last) begin
         dg_step = {raw, {DG_CNT_W{1'b0}}};
      end else begin
         dg_step = {filt, DG_CNT_W'(cnt + 1'b1)};
      end
   endfunction

   logic wr_ctl;
   logic wr_por;
   logic wr_prot;
   logic rc_edge;
   logic flag_set;
   logic flag_clr;
   logic cancel;
   logic [DG_CNT_W:0] bod_step;
   logic [DG_CNT_W:0] lvr_step;

   always_comb begin
      st_nxt = st_r;
      wr_prot = WR_IN & PROTECT_UNLOCK_IN;
      wr_ctl = WR_IN & (ADDR_IN == BROWNOUT_CONTROL_OFS);
      wr_por = wr_prot & (ADDR_IN == POWERON_RESET_MASK_OFS);
      // synchronisers: first stages feed only second stages
      st_nxt.bod_s1 = BOD_RAW_IN;
      st_nxt.bod_s2 = st_r.bod_s1;
      st_nxt.lvr_s1 = LVR_RAW_IN;
      st_nxt.lvr_s2 = st_r.lvr_s1;
      st_nxt.rc_s1 = SLOW_RC_CLOCK_IN;
      st_nxt.rc_s2 = st_r.rc_s1;
      st_nxt.rc_s3 = st_r.rc_s2;
      st_nxt.src_s1 = RESET_SOURCES_IN;
      st_nxt.src_s2 = st_r.src_s1;
      rc_edge = st_r.rc_s2 & ~st_r.rc_s3;

      // protected configuration, then the unprotected interrupt enable write
      if (wr_ctl & PROTECT_UNLOCK_IN) begin
         st_nxt.thr = WDATA_IN[THR_LO +: 3];
         st_nxt.lvr_dg = WDATA_IN[LVR_DG_LO +: 3];
         st_nxt.bod_dg = WDATA_IN[BOD_DG_LO +: 3];
         st_nxt.lvr_en = WDATA_IN[LVR_EN_BIT];
         st_nxt.low_power = WDATA_IN[LOW_POWER_BIT];
         st_nxt.reset_mode = WDATA_IN[RESET_MODE_BIT];
         st_nxt.bod_en = WDATA_IN[ENABLE_BIT];
      end
      if (WR_IN & (ADDR_IN == IRQ_ENABLE_OFS)) begin
         st_nxt.irq_en = WDATA_IN[IRQ_W-1:0];
      end

      // de-glitch filters; the slow RC clock is only sampled, never used as a clock
      bod_step = dg_step(st_r.bod_s2, st_r.bod_filt, st_r.bod_cnt, st_r.bod_dg, rc_edge,
                         1'b0);
      lvr_step = dg_step(st_r.lvr_s2, st_r.lvr_filt, st_r.lvr_cnt, st_r.lvr_dg, 1'b1,
                         1'b1);
      st_nxt.bod_filt = bod_step[DG_CNT_W];
      st_nxt.bod_cnt = bod_step[DG_CNT_W-1:0];
      st_nxt.lvr_filt = lvr_step[DG_CNT_W];
      st_nxt.lvr_cnt = lvr_step[DG_CNT_W-1:0];

      // flag: crossing in either direction; a set in the clearing cycle wins
      flag_set = st_r.bod_en & (st_nxt.bod_filt != st_r.bod_filt);
      flag_clr = (wr_ctl & WDATA_IN[FLAG_BIT]) |
                 (WR_IN & (ADDR_IN == IRQ_CLEAR_OFS) & WDATA_IN[IRQ_BOD_BIT]);
      if (flag_set) begin
         st_nxt.flag = 1'b1;
      end else if (flag_clr) begin
         st_nxt.flag = 1'b0;
      end

      // low-voltage reset settling after the enable rises
      if (~st_nxt.lvr_en) begin
         st_nxt.lvr_armed = 1'b0;
         st_nxt.settle_cnt = '0;
      end else if (~st_r.lvr_en) begin
         st_nxt.lvr_armed = 1'b0;
         st_nxt.settle_cnt = '0;
      end else if (~st_r.lvr_armed) begin
         if (st_r.settle_cnt == SETTLE_CNT_W'(LVR_SETTLE_CYCLES - 1)) begin
            st_nxt.lvr_armed = 1'b1;
         end else begin
            st_nxt.settle_cnt = SETTLE_CNT_W'(st_r.settle_cnt + 1'b1);
         end
      end

      // reset requests
      st_nxt.bod_rst = st_nxt.bod_en & st_nxt.reset_mode & st_nxt.bod_filt;
      st_nxt.lvr_rst = st_nxt.lvr_en & st_nxt.lvr_armed & st_nxt.lvr_filt;

      // power-on reset mask: other reset sources override a same-cycle write
      cancel = (|st_r.src_s2) | st_r.bod_rst | st_r.lvr_rst;
      if (cancel) begin
         st_nxt.por_key = POR_KEY_RST;
      end else if (wr_por) begin
         st_nxt.por_key = WDATA_IN[15:0];
      end
      st_nxt.por_mask = (st_nxt.por_key == POR_MASK_KEY);

      // sticky events
      if (WR_IN & (ADDR_IN == IRQ_CLEAR_OFS)) begin
         st_nxt.irq_stat = st_r.irq_stat & ~WDATA_IN[IRQ_W-1:0];
      end
      if (st_nxt.lvr_armed & ~st_r.lvr_armed) begin
         st_nxt.irq_stat[IRQ_LVR_ARMED_BIT] = 1'b1;
      end
      if (cancel & st_r.por_mask) begin
         st_nxt.irq_stat[IRQ_POR_CANCEL_BIT] = 1'b1;
      end
      st_nxt.irq_stat[IRQ_BOD_BIT] = 1'b0;
      // brown-out interrupt only in interrupt mode and while enabled
      st_nxt.irq = (st_nxt.flag & st_nxt.irq_en[IRQ_BOD_BIT] & st_nxt.bod_en &
                    ~st_nxt.reset_mode) |
                   (|(st_nxt.irq_stat & st_nxt.irq_en));

      // read data stand only in the cycle after the strobe
      st_nxt.rdata = '0;
      if (RD_IN) begin
         case (ADDR_IN)
            BROWNOUT_CONTROL_OFS: begin
               st_nxt.rdata[THR_LO +: 3] = st_r.thr;
               st_nxt.rdata[LVR_DG_LO +: 3] = st_r.lvr_dg;
               st_nxt.rdata[BOD_DG_LO +: 3] = st_r.bod_dg;
               st_nxt.rdata[LVR_EN_BIT] = st_r.lvr_en;
               st_nxt.rdata[LEVEL_STATUS_BIT] = st_r.bod_en & st_r.bod_filt;
               st_nxt.rdata[LOW_POWER_BIT] = st_r.low_power;
               st_nxt.rdata[FLAG_BIT] = st_r.flag;
               st_nxt.rdata[RESET_MODE_BIT] = st_r.reset_mode;
               st_nxt.rdata[ENABLE_BIT] = st_r.bod_en;
            end
            POWERON_RESET_MASK_OFS: begin
               st_nxt.rdata[15:0] = st_r.por_key;
            end
            IRQ_STATUS_OFS: begin
               st_nxt.rdata[IRQ_W-1:0] = st_r.irq_stat;
               st_nxt.rdata[IRQ_BOD_BIT] = st_r.flag;
            end
            IRQ_ENABLE_OFS: begin
               st_nxt.rdata[IRQ_W-1:0] = st_r.irq_en;
            end
            default: begin
               st_nxt.rdata = '0;
            end
         endcase
      end

      if (~RESETN_IN) begin
         st_nxt = '0;
         // reset is synchronous, so the flash word is caught by the clock edge
         st_nxt.thr = USER_CONFIG_WORD_IN[CFG_THR_LO +: 3];
         st_nxt.bod_en = USER_CONFIG_WORD_IN[CFG_ENABLE_BIT];
         st_nxt.reset_mode = USER_CONFIG_WORD_IN[CFG_RESET_MODE_BIT];
         st_nxt.lvr_dg = LVR_DG_RST;
         st_nxt.bod_dg = BOD_DG_RST;
         st_nxt.lvr_en = LVR_EN_RST;
         st_nxt.low_power = LOW_POWER_RST;
         st_nxt.por_key = POR_KEY_RST;
         st_nxt.irq_en = IRQ_ENABLE_RST;
      end
   end

   always_ff @(posedge CLK_IN) begin
      st_r <= st_nxt;
   end

   assign RDATA_OUT = st_r.rdata;
   assign BOD_THRESHOLD_SEL_OUT = st_r.thr;
   assign BOD_ENABLE_OUT = st_r.bod_en;
   assign BOD_LOW_POWER_OUT = st_r.low_power;
   assign LVR_ENABLE_OUT = st_r.lvr_en;
   assign BOD_RESET_REQ_OUT = st_r.bod_rst;
   assign LVR_RESET_REQ_OUT = st_r.lvr_rst;
   assign POR_MASK_OUT = st_r.por_mask;
   assign IRQ_OUT = st_r.irq;

   // checks
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   logic ctl_wr_ok;
   logic ctl_wr_locked;
   assign ctl_wr_ok = WR_IN & PROTECT_UNLOCK_IN & (ADDR_IN == BROWNOUT_CONTROL_OFS);
   assign ctl_wr_locked = WR_IN & ~PROTECT_UNLOCK_IN & (ADDR_IN == BROWNOUT_CONTROL_OFS);

   threshold_write_a: assert property (ctl_wr_ok |=>
      BOD_THRESHOLD_SEL_OUT == $past(WDATA_IN[THR_LO +: 3]))
      else $error("threshold not taken from an unlocked write");

   locked_write_a: assert property (ctl_wr_locked |=>
      $stable(BOD_THRESHOLD_SEL_OUT) && $stable(BOD_ENABLE_OUT) && $stable(LVR_ENABLE_OUT))
      else $error("locked write changed protected configuration");

   level_status_a: assert property ((RD_IN && ADDR_IN == BROWNOUT_CONTROL_OFS &&
      !st_r.bod_en) |=> !RDATA_OUT[LEVEL_STATUS_BIT])
      else $error("level status read 1 with detector disabled");

   flag_clear_a: assert property ((WR_IN && ADDR_IN == BROWNOUT_CONTROL_OFS &&
      WDATA_IN[FLAG_BIT] && !flag_set) |=> !st_r.flag)
      else $error("flag not cleared by write of one");

   bod_reset_gate_a: assert property (BOD_RESET_REQ_OUT |->
      BOD_ENABLE_OUT && st_r.reset_mode && st_r.bod_filt)
      else $error("brown-out reset without enable, reset mode and low level");

   irq_mode_a: assert property ((flag_set && st_r.irq_en[IRQ_BOD_BIT] && st_r.bod_en &&
      !st_r.reset_mode && !ctl_wr_ok) |=> IRQ_OUT [*2])
      else $error("brown-out interrupt not raised in interrupt mode");

   por_mask_set_a: assert property ((WR_IN && PROTECT_UNLOCK_IN &&
      ADDR_IN == POWERON_RESET_MASK_OFS && WDATA_IN[15:0] == POR_MASK_KEY && !cancel)
      |=> POR_MASK_OUT)
      else $error("power-on mask not set by key write");

   por_cancel_a: assert property ((|st_r.src_s2) |=> !POR_MASK_OUT)
      else $error("power-on mask survived another reset source");

   lvr_settle_a: assert property ($rose(st_r.lvr_en) |-> !LVR_RESET_REQ_OUT [*8])
      else $error("low-voltage reset acted inside settling delay");

   deglitch_four_a: assert property (($changed(st_r.lvr_filt) &&
      $past(st_r.lvr_dg, 4) == 3'h1 && st_r.lvr_dg == 3'h1) |->
      ($past(st_r.lvr_s2, 1) == st_r.lvr_filt && $past(st_r.lvr_s2, 4) == st_r.lvr_filt))
      else $error("low-voltage filter changed before four stable cycles");

   flag_rise_c: cover property ($rose(st_r.flag) && !st_r.reset_mode);
   bod_reset_c: cover property ($rose(BOD_RESET_REQ_OUT));
   por_mask_c: cover property ($rose(POR_MASK_OUT) ##[1:20] $fell(POR_MASK_OUT));
   lvr_reset_c: cover property ($rose(LVR_RESET_REQ_OUT));

endmodule

// File: supply_comparator_model.sv
module supply_comparator_model (
   input wire logic clk_in,
   input wire logic [2:0] threshold_sel_in,
   input wire logic enable_in,
   input wire logic low_power_in,
   input wire logic [15:0] supply_mv_in,
   output logic brownout_raw_out,
   output logic lowvolt_raw_out,
   output logic slow_rc_clock_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] LOWVOLT_LEVEL_MV = 16'h05dc;
   logic [2:0] slow_div_r = 3'h0;
   logic [15:0] level_mv;
   initial begin
      slow_rc_clock_out = 1'b0;
      brownout_raw_out = 1'b0;
      lowvolt_raw_out = 1'b0;
   end
   // the rc oscillator runs free, unrelated to the core clock
   always #160 slow_rc_clock_out = ~slow_rc_clock_out;
   assign level_mv = 16'h0640 + 16'h00c8 * {13'h0000, threshold_sel_in};
   // low power only refreshes every eighth clock: slower but cheaper
   always @(posedge clk_in) begin
      slow_div_r <= slow_div_r + 3'h1;
      if (low_power_in !== 1'b1 || slow_div_r == 3'h0) begin
         brownout_raw_out <= (enable_in === 1'b1) && (supply_mv_in < level_mv);
      end
      lowvolt_raw_out <= supply_mv_in < LOWVOLT_LEVEL_MV;
   end
endmodule

// File: testbench.sv
module testbench
   import supply_supervisor_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic unlock = 1'b0;
   logic [3:0] reset_src = 4'h0;
   logic [15:0] supply_mv = 16'h0ce4;
   logic [31:0] rdata;
   logic [2:0] thr_sel;
   logic det_enable, det_low_power, lowvolt_enable, brown_rst_req, lowvolt_rst_req;
   logic mask_out, irq, raw_brown, raw_low, slow_clk;
   int fails = 0;
   int n_tests = 0;
   always #5 clk = ~clk;

   supply_comparator_model far_u (.clk_in(clk), .threshold_sel_in(thr_sel),
      .enable_in(det_enable), .low_power_in(det_low_power), .supply_mv_in(supply_mv),
      .brownout_raw_out(raw_brown), .lowvolt_raw_out(raw_low), .slow_rc_clock_out(slow_clk));

   supply_supervisor_control #(.LVR_SETTLE_CYCLES(16)) dut_u (.CLK_IN(clk), .RESETN_IN(resetn),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
      .PROTECT_UNLOCK_IN(unlock), .USER_CONFIG_WORD_IN(32'h00e0_0000), .BOD_RAW_IN(raw_brown),
      .LVR_RAW_IN(raw_low), .SLOW_RC_CLOCK_IN(slow_clk), .RESET_SOURCES_IN(reset_src),
      .BOD_THRESHOLD_SEL_OUT(thr_sel), .BOD_ENABLE_OUT(det_enable),
      .BOD_LOW_POWER_OUT(det_low_power), .LVR_ENABLE_OUT(lowvolt_enable),
      .BOD_RESET_REQ_OUT(brown_rst_req), .LVR_RESET_REQ_OUT(lowvolt_rst_req),
      .POR_MASK_OUT(mask_out), .IRQ_OUT(irq));

   task automatic finish_test();
      if (fails == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic u);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      unlock <= u;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      // outputs launched by this edge settle before anyone looks at them
      @(negedge clk);
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic set_supply(input logic [15:0] mv);
      @(posedge clk);
      supply_mv <= mv;
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return irq;
         1: return brown_rst_req;
         2: return lowvolt_rst_req;
         default: return mask_out;
      endcase
   endfunction

   // every wait is bounded; running out ends the run at once
   task automatic wait_sig(input int s, input logic v, input int bound, output int n);
      n = 0;
      while (pick(s) !== v) begin
         @(negedge clk);
         n++;
         if (n > bound) begin
            fails++;
            $display("Error wait on output %0d expected %b seen %b", s, v, pick(s));
            finish_test();
         end
      end
   endtask

   function automatic logic [31:0] ctl(input logic [2:0] thr, input logic [2:0] ldg,
         input logic [2:0] bdg, input logic len, input logic fl, input logic rm, input logic en);
      return {13'h0000, thr, 1'b0, ldg, 1'b0, bdg, len, 2'b00, fl, rm, 2'b00, en};
   endfunction

   task automatic s_reset();
      logic [31:0] d;
      reg_rd(BROWNOUT_CONTROL_OFS, d);
      chk("control reset", ctl(3'h7, 3'h0, BOD_DG_RST, 1'b1, 1'b0, 1'b0, 1'b1), d);
      chk("threshold out", 32'h0000_0007, {29'h0, thr_sel});
      chk("lowvolt enable out", 32'h0000_0001, {31'h0, lowvolt_enable});
      reg_rd(POWERON_RESET_MASK_OFS, d);
      chk("mask key reset", 32'h0000_0000, d);
      reg_rd(8'h40, d);
      chk("unmapped read", 32'h0000_0000, d);
   endtask

   task automatic s_protect();
      logic [31:0] d;
      reg_wr(BROWNOUT_CONTROL_OFS, 32'h0000_0000, 1'b0);
      reg_wr(POWERON_RESET_MASK_OFS, 32'h0000_5aa5, 1'b0);
      reg_rd(BROWNOUT_CONTROL_OFS, d);
      chk("locked control", ctl(3'h7, 3'h0, BOD_DG_RST, 1'b1, 1'b0, 1'b0, 1'b1), d);
      chk("locked mask", 32'h0000_0000, {31'h0, mask_out});
      reg_wr(BROWNOUT_CONTROL_OFS, ctl(3'h2, 3'h0, 3'h1, 1'b1, 1'b0, 1'b0, 1'b1) | 32'h20, 1'b1);
      chk("threshold out", 32'h0000_0002, {29'h0, thr_sel});
      chk("low power out", 32'h0000_0001, {31'h0, det_low_power});
   endtask

   task automatic s_filter();
      logic [31:0] d;
      int n;
      for (int c = 0; c < 8; c++) begin
         reg_wr(BROWNOUT_CONTROL_OFS, ctl(3'h2, 3'h0, c[2:0], 1'b1, 1'b1, 1'b0, 1'b1), 1'b1);
         set_supply(16'h06a4);
         wait_sig(0, 1'b1, 600, n);
         if (c > 0) begin
            chk("filter too fast", 32'h1, {31'h0, n >= (2 << c)});
            chk("filter too slow", 32'h1, {31'h0, n <= (2 << c) + 6});
         end else begin
            chk("slow clock sample", 32'h1, {31'h0, n <= 45});
         end
         reg_rd(BROWNOUT_CONTROL_OFS, d);
         chk("below status", ctl(3'h2, 3'h0, c[2:0], 1'b1, 1'b1, 1'b0, 1'b1) | 32'h40, d);
         reg_wr(BROWNOUT_CONTROL_OFS, ctl(3'h2, 3'h0, c[2:0], 1'b1, 1'b0, 1'b0, 1'b1), 1'b0);
         chk("flag kept on zero", 32'h1, {31'h0, irq});
         reg_wr(BROWNOUT_CONTROL_OFS, ctl(3'h2, 3'h0, c[2:0], 1'b1, 1'b1, 1'b0, 1'b1), 1'b0);
         chk("flag cleared", 32'h0, {31'h0, irq});
         set_supply(16'h0ce4);
         wait_sig(0, 1'b1, 600, n);
         reg_rd(BROWNOUT_CONTROL_OFS, d);
         chk("rising cross", ctl(3'h2, 3'h0, c[2:0], 1'b1, 1'b1, 1'b0, 1'b1), d);
      end
   endtask

   task automatic s_irq();
      logic [31:0] d;
      reg_wr(IRQ_ENABLE_OFS, 32'h0000_0000, 1'b0);
      chk("masked irq", 32'h0, {31'h0, irq});
      reg_rd(IRQ_STATUS_OFS, d);
      chk("irq status", 32'h1, d & 32'h1);
      reg_wr(IRQ_ENABLE_OFS, 32'h0000_0001, 1'b0);
      chk("enabled irq", 32'h1, {31'h0, irq});
      reg_wr(IRQ_CLEAR_OFS, 32'h0000_0001, 1'b0);
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask

   task automatic s_reset_mode();
      logic [31:0] d;
      int n;
      reg_wr(POWERON_RESET_MASK_OFS, 32'h0000_5aa5, 1'b1);
      chk("mask on", 32'h1, {31'h0, mask_out});
      reg_wr(BROWNOUT_CONTROL_OFS, ctl(3'h2, 3'h0, 3'h1, 1'b1, 1'b1, 1'b1, 1'b1), 1'b1);
      set_supply(16'h06a4);
      wait_sig(1, 1'b1, 20, n);
      // the mask drops one cycle after the reset request it reacts to
      @(negedge clk);
      chk("no irq in reset mode", 32'h0, {31'h0, irq});
      chk("mask cancelled", 32'h0, {31'h0, mask_out});
      reg_wr(BROWNOUT_CONTROL_OFS, ctl(3'h2, 3'h0, 3'h1, 1'b1, 1'b1, 1'b1, 1'b0), 1'b1);
      wait_sig(1, 1'b0, 8, n);
      reg_rd(BROWNOUT_CONTROL_OFS, d);
      chk("disabled status", 32'h0, d & 32'h41);
      set_supply(16'h0ce4);
   endtask

   task automatic s_mask();
      int n;
      reg_wr(POWERON_RESET_MASK_OFS, 32'h0000_5aa4, 1'b1);
      chk("wrong key", 32'h0, {31'h0, mask_out});
      for (int i = 0; i < 4; i++) begin
         reg_wr(POWERON_RESET_MASK_OFS, 32'h0000_5aa5, 1'b1);
         chk("key mask", 32'h1, {31'h0, mask_out});
         @(posedge clk);
         reset_src <= 4'h1 << i;
         repeat (3) @(posedge clk);
         reset_src <= 4'h0;
         wait_sig(3, 1'b0, 8, n);
         // let the synchronised source drain, or it cancels the next key write
         repeat (3) @(posedge clk);
      end
   endtask

   task automatic s_lowvolt();
      int n;
      reg_wr(BROWNOUT_CONTROL_OFS, ctl(3'h2, 3'h0, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0), 1'b1);
      set_supply(16'h0578);
      repeat (24) @(posedge clk);
      chk("disabled lowvolt", 32'h0, {30'h0, lowvolt_enable, lowvolt_rst_req});
      reg_wr(BROWNOUT_CONTROL_OFS, ctl(3'h2, 3'h0, 3'h1, 1'b1, 1'b1, 1'b0, 1'b0), 1'b1);
      wait_sig(2, 1'b1, 30, n);
      chk("settle delay", 32'h1, {31'h0, n >= 14 && n <= 20});
      for (int g = 0; g < 4; g += 3) begin
         set_supply(16'h0ce4);
         wait_sig(2, 1'b0, 30, n);
         reg_wr(BROWNOUT_CONTROL_OFS, ctl(3'h2, g[2:0], 3'h1, 1'b1, 1'b1, 1'b0, 1'b0), 1'b1);
         set_supply(16'h0578);
         wait_sig(2, 1'b1, 40, n);
         chk("lowvolt filter", 32'h1, {31'h0, n >= (g ? 16 : 0) && n <= (g ? 22 : 6)});
      end
      set_supply(16'h0ce4);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      s_reset();
      s_protect();
      s_filter();
      reg_wr(BROWNOUT_CONTROL_OFS, ctl(3'h2, 3'h0, 3'h1, 1'b1, 1'b1, 1'b0, 1'b1), 1'b1);
      set_supply(16'h06a4);
      repeat (20) @(posedge clk);
      s_irq();
      set_supply(16'h0ce4);
      s_reset_mode();
      s_mask();
      s_lowvolt();
      finish_test();
   end
endmodule
